// ===== verilog/gmer_regs.sv
// GPIO control and measurement input select bank, reached over APB.
// Assumes a scan engine on pclk pulses scan_start and delivers cell results.
//
// Functional notes
// RULE1 - A pin is driven only while its direction bit is one.
// RULE2 - All direction bits are zero after reset; pins start as inputs.
// RULE3 - A driven pin outputs its drive bit.
// RULE4 - Readback field returns each pin's input level; writes to it are ignored.
// RULE5 - Pin levels are sampled once per read of the GPIO register.
// RULE6 - Timer mode overrides pin 3: high while timer counts, low when expired.
// RULE7 - Emergency discharge forces pin 3 timer mode on.
// RULE8 - Emergency discharge is a configuration bit held in its own register.
// RULE9 - Divider connect bit must be set before block voltage scans.
// RULE10 - Separate bits enable block voltage, second and first auxiliary inputs.
// RULE11 - Enables are latched only at scan start; writes apply next scan.
// RULE12 - Twelve bits enable cells one to twelve.
// RULE13 - Results of disabled cells are stored as zero.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gmer_params.svh"

module gmer_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // General-purpose pins
  input wire logic [`GMER_NPIN-1:0] gpio_in,
  output logic [`GMER_NPIN-1:0] gpio_out,
  output logic [`GMER_NPIN-1:0] gpio_oe,
  // Timer and discharge
  input wire logic timer_counting,
  output logic emergency_discharge,
  // Scan engine
  input wire logic scan_start,
  output logic scan_block_divider_connect,
  output logic scan_block_voltage_enable,
  output logic scan_aux_input2_enable,
  output logic scan_aux_input1_enable,
  output logic [`GMER_NCELL-1:0] scan_cell_enable,
  // Cell results
  input wire logic result_valid,
  input wire logic [3:0] result_cell,
  input wire logic [15:0] result_data,
  output logic result_wr,
  output logic [3:0] result_wr_cell,
  output logic [15:0] result_wr_data
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic gmer_hit(input logic [7:0] addr, input logic [7:0] idx);
    gmer_hit = (addr == {idx[5:0], 2'b00});
  endfunction

  logic setup;
  logic wr_access;
  logic hit_gpio;
  logic hit_meas;
  logic hit_emgcy;
  logic err_reg;
  gmer_pkg::gmer_pin_t dir_reg;
  gmer_pkg::gmer_pin_t drive_reg;
  logic tmr_reg;
  logic emgcy_reg;
  gmer_pkg::gmer_word_t meas_reg;
  gmer_pkg::gmer_word_t gpio_word;
  logic cell_on;

  gmer_pin_if pin_bus ();

  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign hit_gpio = gmer_hit(paddr, `GMER_IDX_GPIO);
  assign hit_meas = gmer_hit(paddr, `GMER_IDX_MEAS);
  assign hit_emgcy = gmer_hit(paddr, `GMER_IDX_EMGCY);

  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (setup) begin
      err_reg <= ~(hit_gpio | hit_meas | hit_emgcy);
    end
  end

  // ---------------------------------------------------------------
  // GPIO register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= `GMER_RST_PIN; // [RULE2]
      drive_reg <= `GMER_RST_PIN;
      tmr_reg <= 1'b0;
    end else if (wr_access && hit_gpio) begin
      if (pstrb[1]) begin
        dir_reg <= pwdata[`GMER_DIR_LSB +: `GMER_NPIN]; // [RULE1]
      end
      if (pstrb[0]) begin
        drive_reg <= pwdata[`GMER_DRIVE_LSB +: `GMER_NPIN]; // [RULE3]
        tmr_reg <= pwdata[`GMER_TMR_BIT]; // [RULE6]
      end
    end
  end

  // ---------------------------------------------------------------
  // Emergency discharge register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emgcy_reg <= 1'b0;
    end else if (wr_access && hit_emgcy && pstrb[0]) begin
      emgcy_reg <= pwdata[`GMER_EMGCY_BIT]; // [RULE8]
    end
  end

  assign emergency_discharge = emgcy_reg;

  // ---------------------------------------------------------------
  // Measurement select register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_reg <= `GMER_RST_WORD;
    end else if (wr_access && hit_meas) begin
      if (pstrb[0]) begin
        meas_reg[7:0] <= pwdata[7:0]; // [RULE12]
      end
      if (pstrb[1]) begin
        meas_reg[15:8] <= pwdata[15:8]; // [RULE10] [RULE9]
      end
    end
  end

  // ---------------------------------------------------------------
  // Scan-start latch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_block_divider_connect <= 1'b0;
      scan_block_voltage_enable <= 1'b0;
      scan_aux_input2_enable <= 1'b0;
      scan_aux_input1_enable <= 1'b0;
      scan_cell_enable <= `GMER_RST_CELL;
    end else if (scan_start) begin // [RULE11]
      scan_block_divider_connect <= meas_reg[`GMER_BLKCON_BIT]; // [RULE9]
      scan_block_voltage_enable <= meas_reg[`GMER_BLKEN_BIT]; // [RULE10]
      scan_aux_input2_enable <= meas_reg[`GMER_AIN2_BIT]; // [RULE10]
      scan_aux_input1_enable <= meas_reg[`GMER_AIN1_BIT]; // [RULE10]
      scan_cell_enable <= meas_reg[`GMER_CELL_LSB +: `GMER_NCELL]; // [RULE12]
    end
  end

  // ---------------------------------------------------------------
  // Cell result store
  // ---------------------------------------------------------------
  assign cell_on = (result_cell < `GMER_NCELL_W) ? scan_cell_enable[result_cell] : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_wr <= 1'b0;
      result_wr_cell <= 4'h0;
      result_wr_data <= `GMER_RST_WORD;
    end else begin
      result_wr <= result_valid;
      result_wr_cell <= result_cell;
      result_wr_data <= cell_on ? result_data : `GMER_RST_WORD; // [RULE13]
    end
  end

  // ---------------------------------------------------------------
  // Pin controller
  // ---------------------------------------------------------------
  assign pin_bus.dir = dir_reg;
  assign pin_bus.drive = drive_reg;
  assign pin_bus.tmr_mode = tmr_reg | emgcy_reg; // [RULE7]
  assign pin_bus.tmr_count = timer_counting;

  gmer_pin_ctrl u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pin_bus.pins),
    .gpio_in(gpio_in),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe)
  );

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // The readback field is sampled here, once per read, in the setup cycle.
  assign gpio_word = {dir_reg, pin_bus.level, tmr_reg, 3'h0, drive_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (hit_gpio) begin
        prdata <= {16'h0000, gpio_word}; // [RULE4] [RULE5]
      end else if (hit_meas) begin
        prdata <= {16'h0000, meas_reg};
      end else if (hit_emgcy) begin
        prdata <= {31'h0000_0000, emgcy_reg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_scan_cell_latch: assert property ( // [RULE12]
    scan_start |=> scan_cell_enable == $past(meas_reg[11:0]))
    else $error("cell enables not latched at scan start");
  a_scan_hold: assert property ( // [RULE11]
    !scan_start |=> $stable(scan_cell_enable) && $stable(scan_block_voltage_enable))
    else $error("scan enables changed outside scan start");
  a_scan_inputs: assert property ( // [RULE10]
    scan_start |=> scan_aux_input1_enable == $past(meas_reg[12])
      && scan_aux_input2_enable == $past(meas_reg[13])
      && scan_block_voltage_enable == $past(meas_reg[14]))
    else $error("input enables not latched at scan start");
  a_divider_latch: assert property ( // [RULE9]
    scan_start |=> scan_block_divider_connect == $past(meas_reg[15]))
    else $error("divider connect not latched at scan start");
  a_zero_result: assert property ( // [RULE13]
    result_valid && !cell_on |=> result_wr && result_wr_data == 16'h0000)
    else $error("disabled cell result not zero");
  a_readback_value: assert property ( // [RULE5]
    setup && !pwrite && hit_gpio |=> prdata[11:8] == $past(pin_bus.level))
    else $error("readback does not hold the sampled pin levels");
  a_readback_ro: assert property ( // [RULE4]
    wr_access && hit_gpio |=> prdata == $past(prdata))
    else $error("write disturbed read data");
  a_emgcy_timer: assert property ( // [RULE7]
    emgcy_reg |=> gpio_oe[3] && gpio_out[3] == $past(timer_counting))
    else $error("emergency discharge did not force pin 3 timer mode");
  a_unmapped_err: assert property (
    setup && !(hit_gpio || hit_meas || hit_emgcy) |=> pslverr)
    else $error("unmapped address not flagged");

  c_scan_disabled_cell: cover property (scan_start ##1 (result_valid && !cell_on));
  c_read_gpio: cover property (setup && !pwrite && hit_gpio ##1 pready);
  c_emgcy_on: cover property ($rose(emgcy_reg) && !tmr_reg);
  c_write_meas: cover property (wr_access && hit_meas ##1 scan_start);

endmodule

`default_nettype wire

// ===== shared/gmer_params.svh
// Offsets, field positions, reset values and sizes of the GPIO and measure-enable bank.
// Assumes it is included by bare name from the package and design files.
`ifndef GMER_PARAMS_SVH
`define GMER_PARAMS_SVH

// ---------------------------------------------------------------
// Register indices; byte address is four times the index.
// ---------------------------------------------------------------
`define GMER_IDX_GPIO 8'h11
`define GMER_IDX_MEAS 8'h12
`define GMER_IDX_EMGCY 8'h20

// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define GMER_DIR_LSB 12
`define GMER_RD_LSB 8
`define GMER_TMR_BIT 7
`define GMER_DRIVE_LSB 0
`define GMER_BLKCON_BIT 15
`define GMER_BLKEN_BIT 14
`define GMER_AIN2_BIT 13
`define GMER_AIN1_BIT 12
`define GMER_CELL_LSB 0
`define GMER_EMGCY_BIT 0

// ---------------------------------------------------------------
// Sizes and reset values.
// ---------------------------------------------------------------
`define GMER_NPIN 4
`define GMER_NCELL 12
`define GMER_NCELL_W 4'hc
`define GMER_RST_PIN 4'h0
`define GMER_RST_WORD 16'h0000
`define GMER_RST_CELL 12'h000

`endif

// ===== shared/gmer_pkg.sv
// Types shared by the GPIO and measure-enable bank.
// Assumes gmer_params.svh is on the include path.
`include "gmer_params.svh"

package gmer_pkg;
  typedef logic [`GMER_NPIN-1:0] gmer_pin_t;
  typedef logic [`GMER_NCELL-1:0] gmer_cell_t;
  typedef logic [15:0] gmer_word_t;
endpackage

// ===== shared/gmer_pin_if.sv
// Carrier between the register bank and its pin controller.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
`default_nettype none

interface gmer_pin_if;
  gmer_pkg::gmer_pin_t dir;
  gmer_pkg::gmer_pin_t drive;
  logic tmr_mode;
  logic tmr_count;
  gmer_pkg::gmer_pin_t level;

  modport ctrl (output dir, output drive, output tmr_mode, output tmr_count, input level);
  modport pins (input dir, input drive, input tmr_mode, input tmr_count, output level);
endinterface

`default_nettype wire

// ===== verilog/gmer_pin_ctrl.sv
// Pin controller: synchronises the four pins and drives them from the bank.
// Assumes pins are asynchronous and the timer state is on pclk.
`timescale 1ns/10ps
`default_nettype none
`include "gmer_params.svh"

module gmer_pin_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bank side
  gmer_pin_if.pins pins,
  // Pins
  input wire logic [`GMER_NPIN-1:0] gpio_in,
  output logic [`GMER_NPIN-1:0] gpio_out,
  output logic [`GMER_NPIN-1:0] gpio_oe
);

  gmer_pkg::gmer_pin_t sync1_reg;
  gmer_pkg::gmer_pin_t sync2_reg;
  gmer_pkg::gmer_pin_t sync3_reg;
  gmer_pkg::gmer_pin_t level_reg;
  gmer_pkg::gmer_pin_t settled;

  // ---------------------------------------------------------------
  // Input synchroniser and agreement filter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= `GMER_RST_PIN;
      sync2_reg <= `GMER_RST_PIN;
      sync3_reg <= `GMER_RST_PIN;
    end else begin
      sync1_reg <= gpio_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // A bit only moves once the last two stages agree.
  assign settled = ~(sync2_reg ^ sync3_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= `GMER_RST_PIN;
    end else begin
      level_reg <= (sync3_reg & settled) | (level_reg & ~settled); // [RULE4]
    end
  end

  assign pins.level = level_reg;

  // ---------------------------------------------------------------
  // Output drivers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_oe <= `GMER_RST_PIN; // [RULE2]
      gpio_out <= `GMER_RST_PIN;
    end else begin
      gpio_oe[2:0] <= pins.dir[2:0]; // [RULE1]
      gpio_out[2:0] <= pins.drive[2:0]; // [RULE3]
      if (pins.tmr_mode) begin
        gpio_oe[3] <= 1'b1; // [RULE6]
        gpio_out[3] <= pins.tmr_count; // [RULE6]
      end else begin
        gpio_oe[3] <= pins.dir[3]; // [RULE1]
        gpio_out[3] <= pins.drive[3]; // [RULE3]
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_direction: assert property ( // [RULE1]
    ##1 gpio_oe[2:0] == $past(pins.dir[2:0]))
    else $error("pin enable does not follow direction bits");
  a_pin_drive: assert property ( // [RULE3]
    gpio_oe[0] |-> gpio_out[0] == $past(pins.drive[0]))
    else $error("pin 0 level does not follow drive bit");
  a_pin3_timer: assert property ( // [RULE6]
    pins.tmr_mode |=> gpio_oe[3] && gpio_out[3] == $past(pins.tmr_count))
    else $error("pin 3 does not show timer state in timer mode");
  a_level_filter: assert property ( // [RULE4]
    ##1 ((level_reg ^ $past(level_reg)) & ~$past(settled)) == 4'h0)
    else $error("pin level moved while stages disagreed");
  c_pin3_timer: cover property (pins.tmr_mode ##1 $fell(gpio_out[3]));

endmodule

`default_nettype wire

// ===== verification/gmer_pin_model.sv
// External circuits on the four general-purpose pins.
// Assumes the bench chooses what outside drivers put on pins the device leaves as inputs.
`timescale 1ns/10ps
`default_nettype none

module gmer_pin_model (
  // Device side
  input wire gmer_pkg::gmer_pin_t gpio_out,
  input wire gmer_pkg::gmer_pin_t gpio_oe,
  // Outside drivers
  input wire gmer_pkg::gmer_pin_t ext_level,
  // Pin levels seen by the input buffers
  output gmer_pkg::gmer_pin_t gpio_in
);
  // A driven pin shows the device's level, an input pin the outside driver's level.
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule

`default_nettype wire

// ===== verification/gmer_regs_test.sv
// Self-checking bench for the GPIO and measure-enable bank.
// Assumes the shared package, header and the pin model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "gmer_params.svh"

module gmer_regs_test;
  localparam logic [7:0] ad_gpio = `GMER_IDX_GPIO << 2;
  localparam logic [7:0] ad_meas = `GMER_IDX_MEAS << 2;
  localparam logic [7:0] ad_emg = `GMER_IDX_EMGCY << 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [3:0] pstrb, result_cell, result_wr_cell;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  gmer_pkg::gmer_pin_t gpio_in, gpio_out, gpio_oe, ext_level;
  gmer_pkg::gmer_cell_t scan_cell_enable;
  logic timer_counting, emergency_discharge, scan_start, result_valid, result_wr;
  logic scan_block_divider_connect, scan_block_voltage_enable, scan_aux_input2_enable, scan_aux_input1_enable;
  logic [15:0] result_data, result_wr_data;
  int n_fail, n_checks, gpio_m, meas_m, emg_m, scan_m, i, c, d;

  gmer_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .timer_counting(timer_counting),
    .emergency_discharge(emergency_discharge), .scan_start(scan_start),
    .scan_block_divider_connect(scan_block_divider_connect), .scan_block_voltage_enable(scan_block_voltage_enable),
    .scan_aux_input2_enable(scan_aux_input2_enable), .scan_aux_input1_enable(scan_aux_input1_enable),
    .scan_cell_enable(scan_cell_enable), .result_valid(result_valid), .result_cell(result_cell),
    .result_data(result_data), .result_wr(result_wr), .result_wr_cell(result_wr_cell),
    .result_wr_data(result_wr_data));
  gmer_pin_model pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext_level), .gpio_in(gpio_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // A hang outside a bus cycle ends the run here.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up;
  end

  // -------------------------------------------------------------
  // Reference model
  // -------------------------------------------------------------
  function automatic int tmr_on();
    return ((gpio_m >> 7) | emg_m) & 1;
  endfunction
  function automatic int oe_x();
    return ((gpio_m >> 12) | (tmr_on() << 3)) & 15;
  endfunction
  function automatic int out_x();
    return tmr_on() ? ((gpio_m & 7) | (timer_counting << 3)) : (gpio_m & 15);
  endfunction
  function automatic int pins_x();
    return (oe_x() & out_x()) | (~oe_x() & ext_level);
  endfunction

  // -------------------------------------------------------------
  // Checks, bus cycles and the verdict
  // -------------------------------------------------------------
  task wrap_up;
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk_out(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task chk_rd(input int exp);
    n_checks++;
    if ({e, r} !== {1'b0, 32'(exp)}) begin
      n_fail++;
      $display("mismatch at %0t: read %h err %b expected %h", $time, r, e, exp);
    end
  endtask

  task chk_pins;
    chk_out(gpio_oe, oe_x(), "enable");
    chk_out(gpio_out & gpio_oe, out_x() & oe_x(), "level");
  endtask

  task chk_scan;
    chk_out({scan_block_divider_connect, scan_block_voltage_enable, scan_aux_input2_enable,
      scan_aux_input1_enable, scan_cell_enable}, scan_m, "scan");
  endtask

  // Setup cycle, then access cycles until pready is seen high at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: no bus answer", $time);
      wrap_up;
    end
  endtask

  task wr(input logic [7:0] a, input int v);
    apb(1'b1, a, v);
    if (a == ad_gpio) gpio_m = v & 32'hf08f;
    if (a == ad_meas) meas_m = v & 32'hffff;
    if (a == ad_emg) emg_m = v & 1;
  endtask

  task rd(input logic [7:0] a, input int exp);
    apb(1'b0, a, 32'h0);
    chk_rd(exp);
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    void'($urandom(32'h9eb9));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    ext_level = 4'ha;
    {timer_counting, scan_start, result_valid, result_cell, result_data} = '0;
    {n_fail, n_checks, gpio_m, meas_m, emg_m, scan_m} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk_pins;
    rd(ad_gpio, pins_x() << 8);
    rd(ad_meas, 0);
    // Random direction and drive, with junk in the read-only fields.
    for (i = 0; i < 12; i++) begin
      wr(ad_gpio, $urandom & 32'hff7f);
      ext_level <= 4'($urandom);
      repeat (8) @(posedge pclk);
      chk_pins;
      rd(ad_gpio, gpio_m | (pins_x() << 8));
    end
    // Pin 3 follows the timer, first by its own bit, then by emergency discharge.
    for (i = 0; i < 6; i++) begin
      wr(ad_gpio, ($urandom & 32'hff0f) | (i < 3 ? 32'h80 : 32'h0));
      wr(ad_emg, int'(i >= 3));
      repeat (3) begin
        @(posedge pclk);
        timer_counting <= 1'($urandom);
        @(posedge pclk);
        #1;
        chk_pins;
      end
      chk_out(emergency_discharge, emg_m, "discharge");
      repeat (8) @(posedge pclk);
      rd(ad_gpio, gpio_m | (pins_x() << 8));
    end
    wr(ad_emg, 0);
    repeat (8) @(posedge pclk);
    chk_pins;
    // Unmapped place: error, zero data, write ignored.
    apb(1'b0, 8'h4c, 32'h0);
    chk_out(e, 1, "error");
    chk_out(r, 0, "read");
    wr(8'h4c, 32'hffff);
    rd(ad_gpio, gpio_m | (pins_x() << 8));
    // Byte lanes: lane 0 alone sets drive and timer mode, lane 1 alone clears direction.
    pstrb <= 4'h1;
    apb(1'b1, ad_gpio, 32'hffff);
    gpio_m = (gpio_m & 32'hf000) | 32'h8f;
    pstrb <= 4'h2;
    apb(1'b1, ad_gpio, 32'h0);
    gpio_m = gpio_m & 32'h8f;
    pstrb <= 4'hf;
    repeat (8) @(posedge pclk);
    chk_pins;
    rd(ad_gpio, gpio_m | (pins_x() << 8));
    // Scans: enables latch at scan start only; disabled cells store zero.
    for (i = 0; i < 4; i++) begin
      wr(ad_meas, i == 0 ? 32'hffff : $urandom & 32'hffff);
      rd(ad_meas, meas_m);
      @(posedge pclk);
      scan_start <= 1'b1;
      @(posedge pclk);
      scan_start <= 1'b0;
      scan_m = meas_m;
      #1;
      chk_scan;
      wr(ad_meas, ~meas_m & 32'hffff);
      chk_scan;
      for (c = 0; c < 12; c++) begin
        d = $urandom & 32'hffff;
        @(posedge pclk);
        result_valid <= 1'b1;
        result_cell <= 4'(c);
        result_data <= 16'(d);
        @(posedge pclk);
        result_valid <= 1'b0;
        #1;
        chk_out({result_wr, result_wr_cell, result_wr_data},
          {1'b1, 4'(c), ((scan_m >> c) & 1) ? 16'(d) : 16'h0000}, "result");
      end
    end
    wrap_up;
  end
endmodule

`default_nettype wire
